// [core/beam_eval_pkg.sv]
// constants, codes and layouts for the beam function output evaluator
package beam_eval_pkg;
  // ****************************************
  // geometry and widths
  // ****************************************
  localparam int NUM_BEAMS  = 32;
  localparam int NUM_ZONES  = 4;
  localparam int NUM_CHANGE = 16;
  localparam int ZONE_FUNCS = 5;
  // ****************************************
  // attribute map
  // ****************************************
  localparam logic [7:0] ATTR_ABSORB = 8'h03;
  localparam logic [7:0] ATTR_Q1CFG  = 8'h04;
  // configuration byte fields
  localparam int CFG_FUNC_LSB    = 0;
  localparam int CFG_OP_LSB      = 8;
  localparam int CFG_OPERAND_LSB = 16;
  // reset values
  localparam logic [7:0]  RST_ABSORB  = 8'h00;
  localparam logic [31:0] RST_Q1CFG   = 32'h0000_0000;
  // ****************************************
  // operators
  // ****************************************
  localparam logic [7:0] OP_EQ = 8'h00;
  localparam logic [7:0] OP_GE = 8'h01;
  localparam logic [7:0] OP_LE = 8'h02;
  localparam logic [7:0] OP_NE = 8'h03;
  // ****************************************
  // beam function codes
  // ****************************************
  localparam logic [7:0] FN_BLK_COUNT   = 8'h00;
  localparam logic [7:0] FN_MADE_COUNT  = 8'h01;
  localparam logic [7:0] FN_BLK_FIRST   = 8'h02;
  localparam logic [7:0] FN_MADE_FIRST  = 8'h03;
  localparam logic [7:0] FN_BLK_LAST    = 8'h04;
  localparam logic [7:0] FN_MADE_LAST   = 8'h05;
  localparam logic [7:0] FN_BLK_RUN     = 8'h06;
  localparam logic [7:0] FN_MADE_RUN    = 8'h07;
  localparam logic [7:0] FN_BLK_CENTER  = 8'h08;
  localparam logic [7:0] FN_MADE_CENTER = 8'h09;
  localparam logic [7:0] FN_OUTSIDE     = 8'h0A;
  localparam logic [7:0] FN_INSIDE      = 8'h0B;
  localparam logic [7:0] FN_BEAM_BLK    = 8'h0C;
  localparam logic [7:0] FN_BEAM_MADE   = 8'h0D;
  localparam logic [7:0] FN_TEACH       = 8'h10;
  localparam logic [7:0] FN_CHG_FIRST   = 8'h11;
  localparam logic [7:0] FN_CHG_LAST    = 8'h20;
  localparam logic [7:0] FN_ZONE_BASE   = 8'h21;
  localparam logic [15:0] TEACH_GOOD    = 16'h0064;
  // ****************************************
  // performance options
  // ****************************************
  localparam logic [7:0] PERF_STD       = 8'h00;
  localparam logic [7:0] PERF_HIACC     = 8'h01;
  localparam logic [7:0] PERF_RESERVE   = 8'h02;
  localparam logic [7:0] PERF_CROSS     = 8'h03;
  localparam logic [7:0] PERF_CROSS_RES = 8'h04;
  localparam logic [7:0] PERF_HS        = 8'h05;
  localparam logic [7:0] PERF_HS_HIACC  = 8'h06;
  localparam logic [7:0] PERF_HS_RES    = 8'h07;
  localparam logic [3:0] GROUP_SINGLE   = 4'h1;
  localparam logic [3:0] GROUP_HS       = 4'h4;
  // ****************************************
  // absorption thresholds in percent
  // ****************************************
  localparam logic [7:0] ABS_CODE_30 = 8'h00;
  localparam logic [7:0] ABS_CODE_15 = 8'h01;
  localparam logic [7:0] ABS_CODE_10 = 8'h02;
  localparam logic [7:0] ABS_PCT_30  = 8'h1E;
  localparam logic [7:0] ABS_PCT_15  = 8'h0F;
  localparam logic [7:0] ABS_PCT_10  = 8'h0A;
  localparam logic [7:0] ABS_PCT_OFF = 8'h00;
  // per-vector statistics
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] first;
    logic [15:0] last;
    logic [15:0] run;
  } beam_stat_t;
endpackage

// [core/beam_function_output_evaluator.sv]
// beam state evaluation and switching output one
// Notes on behaviour
// [R1] standard accuracy: blocked only when fully covered
// [R2] high accuracy: half-covered beam counts blocked
// [R3] high reserve forbids high accuracy
// [R4] cross-beam evaluates every second scan
// [R5] high-speed scan activates several beams per cycle
// [R6] transparent absorption code 0/1/2 gives 30/15/10%
// [R7] config: function, operator, 16-bit operand bytes
// [R8] output set when function compares true
// [R9] operator 1 means greater or equal
// [R10] codes 0/1 blocked and made counts
// [R11] codes 2/3 first blocked and made
// [R12] codes 4/5 last blocked and made
// [R13] codes 6/7 longest blocked and made run
// [R14] codes 8/9 central blocked and made
// [R15] code 10 span first to last blocked
// [R16] code 11 made beams inside blocked span
// [R17] codes 12/13 chosen beam blocked or made
// [R18] code 16 teach quality 0 or 100
// [R19] codes 17..32 change channel values
// [R20] codes 33..35 zone 1 count, first, last
// [R21] zones 2..4 start at 38, 43, 48
// [R22] operators 0 eq, 1 ge, 2 le, 3 ne, else off
// [R23] recompute and update output once per scan
`timescale 1ns/100ps
`default_nettype none
module beam_function_output_evaluator
  import beam_eval_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // beam array and scan sequencer
  input  wire logic [NUM_BEAMS-1:0] beam_full_cover,
  input  wire logic [NUM_BEAMS-1:0] beam_half_cover,
  input  wire logic                 scan_done,
  // operating settings
  input  wire logic [7:0]           perf_option,
  input  wire logic                 transparent_mode,
  input  wire logic [15:0]          chosen_beam,
  input  wire logic                 teach_ok,
  input  wire logic [15:0]          change_channel_value [NUM_CHANGE],
  input  wire logic [NUM_BEAMS-1:0] zone_mask [NUM_ZONES],
  // attribute access
  input  wire logic                 attr_wr,
  input  wire logic                 attr_rd,
  input  wire logic [7:0]           attr_id,
  input  wire logic [31:0]          attr_wdata,
  output logic      [31:0]          attr_rdata,
  output logic                      attr_ack,
  output logic                      attr_err,
  // results
  output logic                      switch_out_one,
  output logic                      high_accuracy_active,
  output logic      [3:0]           scan_group_size,
  output logic      [7:0]           absorb_threshold_pct
);

  // ****************************************
  // statistics helper
  // ****************************************
  // count, 1-based first and last index, longest run; zero when empty
  function automatic beam_stat_t beam_stats(input logic [NUM_BEAMS-1:0] v);
    beam_stat_t s;
    logic [15:0] cur;
    s   = '0;
    cur = 16'h0000;
    for (int i = 0; i < NUM_BEAMS; i++) begin
      if (v[i]) begin
        s.count = s.count + 16'h0001;
        if (s.first == 16'h0000) begin
          s.first = 16'(i + 1);
        end
        s.last = 16'(i + 1);
        cur    = cur + 16'h0001;
        if (cur > s.run) begin
          s.run = cur;
        end
      end else begin
        cur = 16'h0000;
      end
    end
    return s;
  endfunction

  function automatic logic [15:0] center_of(input beam_stat_t s);
    return 16'((17'(s.first) + 17'(s.last)) >> 1);
  endfunction

  // ****************************************
  // configuration attributes
  // ****************************************
  logic [7:0]  min_absorption_select;
  logic [31:0] output1_function_config;
  logic [7:0]  next_min_absorption_select;
  logic [31:0] next_output1_function_config;
  logic [31:0] next_attr_rdata;
  logic        next_attr_ack;
  logic        next_attr_err;
  logic [7:0]  cfg_func;
  logic [7:0]  cfg_op;
  logic [15:0] cfg_operand;

  // config fields
  assign cfg_func    = output1_function_config[CFG_FUNC_LSB +: 8];
  assign cfg_op      = output1_function_config[CFG_OP_LSB +: 8];
  assign cfg_operand = output1_function_config[CFG_OPERAND_LSB +: 16];

  // attribute write and read decode
  always_comb begin
    next_min_absorption_select   = min_absorption_select;
    next_output1_function_config = output1_function_config;
    next_attr_rdata              = attr_rdata;
    next_attr_ack                = attr_wr | attr_rd;
    next_attr_err                = 1'b0;
    if (attr_id == ATTR_ABSORB) begin
      if (attr_wr) begin
        next_min_absorption_select = attr_wdata[7:0];
      end
      if (attr_rd) begin
        next_attr_rdata = {24'h000000, min_absorption_select};
      end
    // [R7] four-byte layout
    end else if (attr_id == ATTR_Q1CFG) begin
      if (attr_wr) begin
        next_output1_function_config = attr_wdata;
      end
      if (attr_rd) begin
        next_attr_rdata = output1_function_config;
      end
    end else if (attr_wr | attr_rd) begin
      next_attr_rdata = 32'h0000_0000;
      next_attr_err   = 1'b1;
    end
  end

  // attribute registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      min_absorption_select   <= RST_ABSORB;
      output1_function_config <= RST_Q1CFG;
      attr_rdata              <= 32'h0000_0000;
      attr_ack                <= 1'b0;
      attr_err                <= 1'b0;
    end else begin
      min_absorption_select   <= next_min_absorption_select;
      output1_function_config <= next_output1_function_config;
      attr_rdata              <= next_attr_rdata;
      attr_ack                <= next_attr_ack;
      attr_err                <= next_attr_err;
    end
  end

  // ****************************************
  // performance options
  // ****************************************
  logic       hi_acc_req;
  logic       reserve_on;
  logic       cross_on;
  logic       hs_on;
  logic       hi_acc;
  logic [7:0] next_absorb_pct;

  // option decode
  assign hi_acc_req = (perf_option == PERF_HIACC) | (perf_option == PERF_HS_HIACC);
  assign reserve_on = (perf_option == PERF_RESERVE) | (perf_option == PERF_CROSS_RES)
                    | (perf_option == PERF_HS_RES);
  assign cross_on   = (perf_option == PERF_CROSS) | (perf_option == PERF_CROSS_RES);
  assign hs_on      = (perf_option == PERF_HS) | (perf_option == PERF_HS_HIACC)
                    | (perf_option == PERF_HS_RES);
  // [R3] reserve blocks accuracy
  assign hi_acc     = hi_acc_req & ~reserve_on;

  // [R6] absorption threshold table
  always_comb begin
    next_absorb_pct = ABS_PCT_OFF;
    if (transparent_mode) begin
      if (min_absorption_select == ABS_CODE_30) begin
        next_absorb_pct = ABS_PCT_30;
      end else if (min_absorption_select == ABS_CODE_15) begin
        next_absorb_pct = ABS_PCT_15;
      end else if (min_absorption_select == ABS_CODE_10) begin
        next_absorb_pct = ABS_PCT_10;
      end
    end
  end

  // ****************************************
  // beam statistics
  // ****************************************
  logic [NUM_BEAMS-1:0] blocked_vec;
  logic [NUM_BEAMS-1:0] made_vec;
  beam_stat_t           blk_st;
  beam_stat_t           made_st;
  logic [15:0]          outside_span;
  logic [15:0]          zone_val [NUM_ZONES];
  logic                 zone_hit [NUM_ZONES];

  // [R1] [R2] full cover, or half cover at high accuracy
  assign blocked_vec  = hi_acc ? (beam_full_cover | beam_half_cover) : beam_full_cover;
  assign made_vec     = ~blocked_vec;
  assign blk_st       = beam_stats(blocked_vec);
  assign made_st      = beam_stats(made_vec);
  // [R15] first to last blocked
  assign outside_span = (blk_st.count == 16'h0000) ? 16'h0000
                      : 16'(blk_st.last - blk_st.first + 16'h0001);

  // [R20] [R21] per-zone blocked evaluations
  for (genvar z = 0; z < NUM_ZONES; z++) begin : g_zone
    localparam logic [7:0] BASE = 8'(int'(FN_ZONE_BASE) + z * ZONE_FUNCS);
    beam_stat_t zs;
    logic [7:0] k;
    assign zs          = beam_stats(blocked_vec & zone_mask[z]);
    assign k           = 8'(cfg_func - BASE);
    assign zone_hit[z] = (cfg_func >= BASE) && (k < 8'(ZONE_FUNCS));
    assign zone_val[z] = (k == 8'h00) ? zs.count
                       : (k == 8'h01) ? zs.first
                       : (k == 8'h02) ? zs.last
                       : (k == 8'h03) ? zs.run
                       : center_of(zs);
  end

  // ****************************************
  // function select and compare
  // ****************************************
  logic [15:0] sel_value;
  logic        sel_valid;
  logic        chosen_ok;
  logic        chosen_blk;
  logic        cond_true;

  assign chosen_ok  = (chosen_beam != 16'h0000) && (chosen_beam <= 16'(NUM_BEAMS));
  assign chosen_blk = chosen_ok & blocked_vec[5'(chosen_beam - 16'h0001)];

  // selected function value
  always_comb begin
    sel_value = 16'h0000;
    sel_valid = 1'b1;
    case (cfg_func)
      // [R10] counts
      FN_BLK_COUNT:   sel_value = blk_st.count;
      FN_MADE_COUNT:  sel_value = made_st.count;
      // [R11] first indices
      FN_BLK_FIRST:   sel_value = blk_st.first;
      FN_MADE_FIRST:  sel_value = made_st.first;
      // [R12] last indices
      FN_BLK_LAST:    sel_value = blk_st.last;
      FN_MADE_LAST:   sel_value = made_st.last;
      // [R13] longest runs
      FN_BLK_RUN:     sel_value = blk_st.run;
      FN_MADE_RUN:    sel_value = made_st.run;
      // [R14] central beams
      FN_BLK_CENTER:  sel_value = center_of(blk_st);
      FN_MADE_CENTER: sel_value = center_of(made_st);
      FN_OUTSIDE:     sel_value = outside_span;
      // [R16] made inside blocked span
      FN_INSIDE:      sel_value = 16'(outside_span - blk_st.count);
      // [R17] chosen beam tests
      FN_BEAM_BLK:    sel_value = {15'h0000, chosen_blk};
      FN_BEAM_MADE:   sel_value = {15'h0000, chosen_ok & ~chosen_blk};
      // [R18] teach quality
      FN_TEACH:       sel_value = teach_ok ? TEACH_GOOD : 16'h0000;
      default: begin
        sel_valid = 1'b0;
        // [R19] change channels
        if ((cfg_func >= FN_CHG_FIRST) && (cfg_func <= FN_CHG_LAST)) begin
          sel_value = change_channel_value[4'(cfg_func - FN_CHG_FIRST)];
          sel_valid = 1'b1;
        end
        for (int z = 0; z < NUM_ZONES; z++) begin
          if (zone_hit[z]) begin
            sel_value = zone_val[z];
            sel_valid = 1'b1;
          end
        end
      end
    endcase
  end

  // [R8] [R9] [R22] operator compare
  always_comb begin
    cond_true = 1'b0;
    if (sel_valid) begin
      if (cfg_op == OP_EQ) begin
        cond_true = (sel_value == cfg_operand);
      end else if (cfg_op == OP_GE) begin
        cond_true = (sel_value >= cfg_operand);
      end else if (cfg_op == OP_LE) begin
        cond_true = (sel_value <= cfg_operand);
      end else if (cfg_op == OP_NE) begin
        cond_true = (sel_value != cfg_operand);
      end
    end
  end

  // ****************************************
  // scan evaluation and outputs
  // ****************************************
  logic       second_half;
  logic       eval_pulse;
  logic       next_second_half;
  logic       next_switch_out_one;
  logic [3:0] next_group;

  // [R4] cross-beam needs two scans
  assign eval_pulse = scan_done & (~cross_on | second_half);

  // [R23] update once per completed scan
  always_comb begin
    next_second_half    = second_half;
    next_switch_out_one = switch_out_one;
    if (scan_done) begin
      next_second_half = cross_on & ~second_half;
    end
    if (eval_pulse) begin
      next_switch_out_one = cond_true;
    end
    // [R5] several beams per cycle
    next_group = hs_on ? GROUP_HS : GROUP_SINGLE;
  end

  // evaluation registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      second_half          <= 1'b0;
      switch_out_one       <= 1'b0;
      high_accuracy_active <= 1'b0;
      scan_group_size      <= GROUP_SINGLE;
      absorb_threshold_pct <= ABS_PCT_OFF;
    end else begin
      second_half          <= next_second_half;
      switch_out_one       <= next_switch_out_one;
      high_accuracy_active <= hi_acc;
      scan_group_size      <= next_group;
      absorb_threshold_pct <= next_absorb_pct;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  AST_GE_COMPARE: assert property (@(posedge core_clk) disable iff (rst) // [R9]
    eval_pulse && sel_valid && cfg_op == OP_GE
      |=> switch_out_one == ($past(sel_value) >= $past(cfg_operand)))
    else $error("greater-or-equal result wrong");
  AST_BAD_OP_OFF: assert property (@(posedge core_clk) disable iff (rst) // [R22]
    eval_pulse && cfg_op > OP_NE |=> !switch_out_one)
    else $error("unknown operator drove output");
  AST_HOLD_BETWEEN: assert property (@(posedge core_clk) disable iff (rst) // [R23]
    !eval_pulse |=> $stable(switch_out_one))
    else $error("output changed without scan");
  AST_RESERVE_NO_ACC: assert property (@(posedge core_clk) disable iff (rst) // [R3]
    reserve_on ##1 reserve_on |-> !high_accuracy_active)
    else $error("high accuracy with high reserve");
  AST_CROSS_SKIP: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    cross_on && scan_done && !second_half |=> $stable(switch_out_one))
    else $error("cross mode evaluated first scan");
  AST_ABS_15: assert property (@(posedge core_clk) disable iff (rst) // [R6]
    attr_wr && attr_id == ATTR_ABSORB && attr_wdata[7:0] == ABS_CODE_15
      && transparent_mode ##1 transparent_mode |=> absorb_threshold_pct == ABS_PCT_15)
    else $error("absorption code one not 15 percent");
  AST_CFG_STORE: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    attr_wr && attr_id == ATTR_Q1CFG |=> cfg_operand == $past(attr_wdata[31:16])
      && cfg_func == $past(attr_wdata[7:0]))
    else $error("config bytes misplaced");
  AST_BLK_COUNT: assert property (@(posedge core_clk) disable iff (rst) // [R10]
    eval_pulse && cfg_func == FN_BLK_COUNT && cfg_op == OP_EQ
      |=> switch_out_one == ($countones($past(blocked_vec)) == int'($past(cfg_operand))))
    else $error("blocked count compare wrong");
  AST_FULL_ONLY: assert property (@(posedge core_clk) disable iff (rst) // [R1]
    !hi_acc |-> blocked_vec == beam_full_cover)
    else $error("half cover counted at standard accuracy");
  AST_HS_GROUP: assert property (@(posedge core_clk) disable iff (rst) // [R5]
    hs_on |=> scan_group_size == GROUP_HS)
    else $error("high-speed group size missing");

endmodule
`default_nettype wire

// [verification/beam_array_model.sv]
// optical beam array model handing complete scan vectors to the evaluator
`timescale 1ns/100ps
`default_nettype none
module beam_array_model
  import beam_eval_pkg::*;
(
  // clock
  input  wire logic                 core_clk,
  // scan request from the bench
  input  wire logic                 fire,
  input  wire logic [NUM_BEAMS-1:0] next_full,
  input  wire logic [NUM_BEAMS-1:0] next_half,
  // receiver side outputs
  output logic      [NUM_BEAMS-1:0] beam_full_cover,
  output logic      [NUM_BEAMS-1:0] beam_half_cover,
  output logic                      scan_done
);
  // vectors valid only with scan_done, they invert on every cycle without fire
  always_ff @(posedge core_clk) begin
    scan_done <= fire;
    if (fire) begin
      beam_full_cover <= next_full;
      beam_half_cover <= next_half;
    end else begin
      beam_full_cover <= ~beam_full_cover;
      beam_half_cover <= ~beam_half_cover;
    end
  end
endmodule
`default_nettype wire

// [verification/beam_function_output_evaluator_test.sv]
// self-checking bench for the beam function output evaluator
`timescale 1ns/100ps
`default_nettype none
module beam_function_output_evaluator_test
  import beam_eval_pkg::*;
;
  logic core_clk, rst, fire, transparent_mode, teach_ok, attr_wr, attr_rd;
  logic [31:0] next_full, next_half, beam_full_cover, beam_half_cover, attr_wdata, attr_rdata;
  logic scan_done, attr_ack, attr_err, switch_out_one, high_accuracy_active;
  logic [7:0] perf_option, attr_id, absorb_threshold_pct;
  logic [15:0] chosen_beam;
  logic [15:0] chg [NUM_CHANGE];
  logic [31:0] zm [NUM_ZONES];
  logic [3:0] scan_group_size;
  logic [31:0] rd;
  logic ack, err;
  int n_mismatch, cmp_count;
  // ****************************************
  // design and far side
  // ****************************************
  beam_function_output_evaluator i_dut (.core_clk(core_clk), .rst(rst),
    .beam_full_cover(beam_full_cover), .beam_half_cover(beam_half_cover),
    .scan_done(scan_done), .perf_option(perf_option), .transparent_mode(transparent_mode),
    .chosen_beam(chosen_beam), .teach_ok(teach_ok), .change_channel_value(chg),
    .zone_mask(zm), .attr_wr(attr_wr), .attr_rd(attr_rd), .attr_id(attr_id),
    .attr_wdata(attr_wdata), .attr_rdata(attr_rdata), .attr_ack(attr_ack),
    .attr_err(attr_err), .switch_out_one(switch_out_one),
    .high_accuracy_active(high_accuracy_active), .scan_group_size(scan_group_size),
    .absorb_threshold_pct(absorb_threshold_pct));
  beam_array_model i_array (.core_clk(core_clk), .fire(fire), .next_full(next_full),
    .next_half(next_half), .beam_full_cover(beam_full_cover),
    .beam_half_cover(beam_half_cover), .scan_done(scan_done));
  // ****************************************
  // reporting
  // ****************************************
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic check_vec(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // ****************************************
  // expectations
  // ****************************************
  function automatic logic [15:0] stat(input logic [31:0] v, input int k);
    int cnt = 0, fst = 0, lst = 0, run = 0, cur = 0;
    for (int i = 0; i < 32; i++) begin
      cur = v[i] ? cur + 1 : 0;
      if (cur > run) run = cur;
      if (v[i]) begin
        cnt++;
        lst = i + 1;
        if (fst == 0) fst = i + 1;
      end
    end
    case (k)
      0: return 16'(cnt);
      1: return 16'(fst);
      2: return 16'(lst);
      3: return 16'(run);
      4: return 16'((fst + lst) / 2);
      5: return (cnt > 0) ? 16'(lst - fst + 1) : 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] fn_value(input int code, input logic [31:0] blk);
    int c = int'(chosen_beam);
    if (code <= 9) return stat(code[0] ? ~blk : blk, code / 2);
    if (code == 10) return stat(blk, 5);
    if (code == 11) return stat(blk, 5) - stat(blk, 0);
    if (code == 12 || code == 13) begin
      if (c < 1 || c > 32) return 16'h0000;
      return 16'(blk[c-1] ^ code[0]);
    end
    if (code == 16) return teach_ok ? TEACH_GOOD : 16'h0000;
    if (code >= 17 && code <= 32) return chg[code-17];
    if (code < 33 || code > 52) return 16'h0000; // unknown codes, keep operand defined
    return stat(blk & zm[(code-33)/5], (code - 33) % 5);
  endfunction
  function automatic logic fn_true(input int code, input int op, input logic [15:0] val,
                                   input logic [15:0] rhs);
    if (code == 14 || code == 15 || code > 52) return 1'b0;
    case (op)
      0: return val == rhs;
      1: return val >= rhs;
      2: return val <= rhs;
      3: return val != rhs;
      default: return 1'b0;
    endcase
  endfunction
  // ****************************************
  // drivers
  // ****************************************
  task automatic attr_op(input logic wr, input logic [7:0] id, input logic [31:0] d);
    @(posedge core_clk);
    attr_wr <= wr;
    attr_rd <= ~wr;
    attr_id <= id;
    attr_wdata <= d;
    @(posedge core_clk);
    attr_wr <= 1'b0;
    attr_rd <= 1'b0;
    #1;
    rd = attr_rdata;
    ack = attr_ack;
    err = attr_err;
    check_bit(ack, 1'b1, "attribute ack");
  endtask
  task automatic do_scan(input logic [31:0] f, input logic [31:0] h);
    @(posedge core_clk);
    fire <= 1'b1;
    next_full <= f;
    next_half <= h;
    @(posedge core_clk);
    fire <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic run_case(input int code, input int op, input int perf);
    logic [31:0] f, h, blk;
    logic [15:0] val, rhs;
    @(posedge core_clk);
    perf_option <= 8'(perf);
    teach_ok <= 1'($urandom);
    chosen_beam <= 16'($urandom % 34);
    foreach (chg[i]) chg[i] <= 16'($urandom % 8);
    foreach (zm[i]) zm[i] <= $urandom;
    f = $urandom & $urandom;
    h = f | $urandom;
    @(posedge core_clk);
    blk = (perf == 1 || perf == 6) ? h : f;
    val = fn_value(code, blk);
    case ($urandom % 4)
      0: rhs = val;
      1: rhs = val + 16'h0001;
      2: rhs = val - 16'(val != 0);
      default: rhs = 16'($urandom % 40);
    endcase
    attr_op(1'b1, ATTR_Q1CFG, {rhs, 8'(op), 8'(code)});
    do_scan(f, h);
    if (perf == 3 || perf == 4) do_scan(f, h);
    check_bit(switch_out_one, fn_true(code, op, val, rhs), "output one");
  endtask
  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    {rst, fire, transparent_mode, teach_ok, attr_wr, attr_rd} = 6'b110000;
    {next_full, next_half, attr_wdata, attr_id, perf_option, chosen_beam} = '0;
    foreach (chg[i]) chg[i] = '0;
    foreach (zm[i]) zm[i] = '0;
    void'($urandom(24));
    @(posedge core_clk);
    fire <= 1'b0; // array now holds defined vectors
    repeat (15) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check_bit(switch_out_one, 1'b0, "reset output");
    check_vec(32'(scan_group_size), 32'h1, "reset group");
    attr_op(1'b0, ATTR_Q1CFG, '0);
    check_vec(rd, RST_Q1CFG, "reset config");
    attr_op(1'b1, ATTR_Q1CFG, 32'h1234_0205);
    attr_op(1'b0, ATTR_Q1CFG, '0);
    check_vec(rd, 32'h1234_0205, "config readback");
    attr_op(1'b1, 8'h05, 32'hFFFF_FFFF);
    check_bit(err, 1'b1, "unmapped write");
    attr_op(1'b0, 8'h05, '0);
    check_vec(rd, 32'h0, "unmapped read");
    // performance options, high accuracy and group size
    for (int p = 0; p < 8; p++) begin
      @(posedge core_clk);
      perf_option <= 8'(p);
      repeat (2) @(posedge core_clk);
      #1;
      check_bit(high_accuracy_active, p == 1 || p == 6, "accuracy");
      check_vec(32'(scan_group_size), p >= 5 ? 32'h4 : 32'h1, "group");
    end
    // absorption codes in and out of transparent mode
    for (int t = 0; t < 2; t++) begin
      for (int a = 0; a < 4; a++) begin
        @(posedge core_clk);
        transparent_mode <= 1'(t);
        attr_op(1'b1, ATTR_ABSORB, 32'(a));
        @(posedge core_clk);
        #1;
        check_vec(32'(absorb_threshold_pct),
                  (t == 0 || a > 2) ? 32'h0 : (a == 0 ? 32'h1E : a == 1 ? 32'h0F : 32'h0A),
                  "absorption");
      end
    end
    // half covered beam counts only at high accuracy
    run_case(0, 1, 0);
    run_case(0, 1, 1);
    // every function code and operator, random vectors
    for (int rep = 0; rep < 6; rep++) begin
      for (int c = 0; c < 56; c++) begin
        run_case(c, (rep < 5) ? rep : int'($urandom % 4), int'($urandom % 8));
      end
    end
    // back to back scans, last one decides
    run_case(0, 3, 0);
    attr_op(1'b1, ATTR_Q1CFG, 32'h0000_0000);
    @(posedge core_clk);
    fire <= 1'b1;
    next_full <= 32'h0000_0000;
    @(posedge core_clk);
    next_full <= 32'h0000_0001;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check_bit(switch_out_one, 1'b0, "last scan decides");
    test_done();
  end
endmodule
`default_nettype wire
